// ---- hdl/irq_ctrl_pkg.sv ----
// Constants, types and register map of the prioritized interrupt controller
// What this block does
// - Accept GPIO, supply, sleep, digital, analog requests
// - Per-source enable bit in two masks
// - Global enable flag gates all interrupts
// - Reset clears masks and global enable
// - Vector read gives highest pending vector
// - Any vector write clears all pending except sources with an event that cycle
// - Mask race yields taken interrupt, vector zero
// - One pending flop per source, set on event
// - Pending holds until serviced, reset, vector write
// - Request only when mask and global set
// - GPIO event needs pin enable and type
// - Analog event needs source selection configured
// - Acknowledge runs 13-cycle call pushing PC, flags
// - Flags cleared after flags copy pushed
// - Return restores the saved flags
// - Lower priority number serviced first
// - Nesting allowed when handler sets enable
// - Distinct vector per source
// - Vector is four times priority number
package irq_ctrl_pkg;

   localparam int NUM_SRC = 15;

   // Register word indices; byte address on APB is four times the index
   localparam logic [11:0] IDX_GEN_MASK  = 12'h0e0;
   localparam logic [11:0] IDX_DIG_MASK  = 12'h0e1;
   localparam logic [11:0] IDX_VECTOR    = 12'h0e2;
   localparam logic [11:0] IDX_FLAGS     = 12'h0e3;
   localparam logic [11:0] IDX_PEND      = 12'h0e4;
   localparam logic [11:0] IDX_SRC_CFG   = 12'h0e5;

   // Reset values
   localparam logic [7:0] GEN_MASK_RST = 8'h00;
   localparam logic [7:0] DIG_MASK_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST    = 8'h00;
   localparam logic [7:0] SRC_CFG_RST  = 8'h00;

   // Field positions
   localparam int FLAG_IE_BIT    = 0;
   localparam int CFG_GPIO_EN    = 0;
   localparam int CFG_GPIO_TYPE  = 1;
   localparam int CFG_ACOL_SEL   = 4;

   // Source bit positions inside the pending vector (priority - 1)
   localparam int SRC_SUPPLY = 0;
   localparam int SRC_DIG0   = 1;
   localparam int SRC_ACOL0  = 9;
   localparam int SRC_GPIO   = 13;
   localparam int SRC_SLEEP  = 14;

   localparam int VEC_STEP       = 4;
   localparam int ACK_CALL_CYC   = 13;
   localparam int FLAGS_PUSH_CYC = 9;

   typedef enum {
      CPU_RUN,
      CPU_CALL,
      CPU_RET
   } cpu_state_t;

   // Requests from the sources
   typedef struct packed {
      logic       supply;
      logic [7:0] digital;
      logic [3:0] analog;
      logic       gpio;
      logic       sleep;
   } irq_src_t;

   // Core-side handshake
   typedef struct packed {
      logic boundary;
      logic return_from_interrupt;
      logic setIe;
   } core_req_t;

endpackage

// ---- hdl/prioritized_interrupt_controller.sv ----
// Interrupt controller with pending flags, masks, vectoring and acknowledge
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module prioritized_interrupt_controller
   import irq_ctrl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire irq_src_t    srcEvent,
   input  wire core_req_t   coreReq,
   output logic             irqRequest,
   output logic             ackBusy,
   output logic      [7:0]  ackVector,
   output logic             pushPcHigh,
   output logic             pushPcLow,
   output logic             pushFlags
);

   logic [7:0]         genMask_q;
   logic [7:0]         digMask_q;
   logic [7:0]         flags_q;
   logic [7:0]         savedFlags_q;
   logic [7:0]         srcCfg_q;
   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] evtRaw;
   logic [NUM_SRC-1:0] enabled;
   logic [3:0]         callCnt_q;
   logic [7:0]         latchedVec_q;
   logic [3:0]         latchedSrc_q;
   logic               latchedValid_q;
   cpu_state_t         state_q;
   logic               wrEn;
   logic               rdEn;
   logic [9:0]         wordIdx;
   logic               vecWrite;
   logic               maskWrite;

   // Highest-priority pending source, index 0 wins
   function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
      logic [3:0] idx;
      idx = 4'hf;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   // Vector for a source index, 0 when none
   // distinct vectors, four apart
   function automatic logic [7:0] vec_of(input logic [3:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx != 4'hf) begin
         v = 8'((32'(idx) + 1) * VEC_STEP);
      end
      return v;
   endfunction

   // APB decode; zero-wait access
   assign wordIdx   = paddr[11:2];
   assign wrEn      = psel && penable && pwrite;
   assign rdEn      = psel && penable && !pwrite;
   assign vecWrite  = wrEn && (wordIdx == IDX_VECTOR[9:0]);
   assign maskWrite = wrEn && ((wordIdx == IDX_GEN_MASK[9:0]) ||
                               (wordIdx == IDX_DIG_MASK[9:0]));

   // Event qualification and source ordering
   always_comb begin
      evtRaw = '0;
      evtRaw[SRC_SUPPLY]          = srcEvent.supply;
      evtRaw[SRC_DIG0 +: 8]       = srcEvent.digital;
      evtRaw[SRC_SLEEP]           = srcEvent.sleep;
      evtRaw[SRC_GPIO] = srcEvent.gpio && srcCfg_q[CFG_GPIO_EN] &&
                         srcCfg_q[CFG_GPIO_TYPE];
      evtRaw[SRC_ACOL0 +: 4] = srcEvent.analog &
                               srcCfg_q[CFG_ACOL_SEL +: 4];
   end

   always_comb begin
      enabled = '0;
      enabled[SRC_SUPPLY]    = genMask_q[0];
      enabled[SRC_ACOL0 +: 4] = genMask_q[4:1];
      enabled[SRC_GPIO]      = genMask_q[5];
      enabled[SRC_SLEEP]     = genMask_q[6];
      enabled[SRC_DIG0 +: 8] = digMask_q;
   end

   // Mask registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         genMask_q <= GEN_MASK_RST;
         digMask_q <= DIG_MASK_RST;
      end else if (wrEn && wordIdx == IDX_GEN_MASK[9:0]) begin
         genMask_q <= pwdata[7:0];
      end else if (wrEn && wordIdx == IDX_DIG_MASK[9:0]) begin
         digMask_q <= pwdata[7:0];
      end
   end

   // Source configuration register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         srcCfg_q <= SRC_CFG_RST;
      end else if (wrEn && wordIdx == IDX_SRC_CFG[9:0]) begin
         srcCfg_q <= pwdata[7:0];
      end
   end

   // Pending flags; new events win over any clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pend_q <= '0;
      end else begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (evtRaw[i]) begin
               pend_q[i] <= 1'b1;
            end else if (vecWrite) begin
               pend_q[i] <= 1'b0;
            end else if (state_q == CPU_CALL && callCnt_q == 4'd0 &&
                         latchedValid_q && latchedSrc_q == 4'(i)) begin
               pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // Flags register with global enable
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flags_q      <= FLAGS_RST;
         savedFlags_q <= FLAGS_RST;
      end else if (state_q == CPU_CALL &&
                   callCnt_q == 4'(FLAGS_PUSH_CYC)) begin
         savedFlags_q <= flags_q;
         flags_q      <= FLAGS_RST;
      end else if (coreReq.return_from_interrupt && state_q == CPU_RUN) begin
         flags_q <= savedFlags_q;
      end else if (wrEn && wordIdx == IDX_FLAGS[9:0]) begin
         flags_q <= pwdata[7:0];
      end else if (coreReq.setIe) begin
         flags_q[FLAG_IE_BIT] <= 1'b1;
      end
   end

   // Acknowledge sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q        <= CPU_RUN;
         callCnt_q      <= '0;
         latchedVec_q   <= 8'h00;
         latchedSrc_q   <= 4'hf;
         latchedValid_q <= 1'b0;
      end else begin
         case (state_q)
            CPU_RUN: begin
               if (coreReq.boundary && irqRequest) begin
                  state_q   <= CPU_CALL;
                  callCnt_q <= '0;
                  if (maskWrite) begin
                     latchedValid_q <= 1'b0;
                     latchedSrc_q   <= 4'hf;
                  end else begin
                     latchedValid_q <= 1'b1;
                     latchedSrc_q   <= first_set(pend_q & enabled);
                  end
               end
            end
            CPU_CALL: begin
               if (callCnt_q == 4'd0) begin
                  latchedVec_q <= vec_of(latchedSrc_q);
               end
               if (callCnt_q == 4'(ACK_CALL_CYC - 1)) begin
                  state_q <= CPU_RUN;
               end
               callCnt_q <= callCnt_q + 4'd1;
            end
            default: begin
               state_q <= CPU_RUN;
            end
         endcase
      end
   end

   // Core-facing outputs, all registered
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irqRequest <= 1'b0;
         ackBusy    <= 1'b0;
         ackVector  <= 8'h00;
         pushPcHigh <= 1'b0;
         pushPcLow  <= 1'b0;
         pushFlags  <= 1'b0;
      end else begin
         irqRequest <= |(pend_q & enabled) && flags_q[FLAG_IE_BIT] &&
                       !(state_q == CPU_CALL);
         ackBusy    <= (state_q == CPU_CALL);
         ackVector  <= latchedVec_q;
         pushPcHigh <= state_q == CPU_CALL && callCnt_q == 4'd3;
         pushPcLow  <= state_q == CPU_CALL && callCnt_q == 4'd6;
         pushFlags  <= state_q == CPU_CALL &&
                       callCnt_q == 4'(FLAGS_PUSH_CYC);
      end
   end

   // APB read data and response
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= '0;
            case (wordIdx)
               IDX_GEN_MASK[9:0]: prdata[7:0] <= genMask_q;
               IDX_DIG_MASK[9:0]: prdata[7:0] <= digMask_q;
               IDX_VECTOR[9:0]: prdata[7:0] <= vec_of(first_set(pend_q));
               IDX_FLAGS[9:0]: prdata[7:0] <= flags_q;
               IDX_PEND[9:0]: prdata[NUM_SRC-1:0] <= pend_q;
               IDX_SRC_CFG[9:0]: prdata[7:0] <= srcCfg_q;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Unused read strobe kept out of logic
   logic unusedRd;
   assign unusedRd = rdEn;

endmodule

// ---- testbench/irq_ctrl_checker.sv ----
// Port assertions for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_checker
   import irq_ctrl_pkg::*;
(
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire core_req_t  coreReq,
   input wire logic       irqRequest,
   input wire logic       ackBusy,
   input wire logic [7:0] ackVector,
   input wire logic       pushPcHigh,
   input wire logic       pushPcLow,
   input wire logic       pushFlags
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Bus and reset behaviour
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   reset_quiet_a: assert property ($rose(nrst) |-> !irqRequest)
      else $error("request right after reset");
   // Acknowledge call shape
   ack_start_a: assert property (irqRequest && coreReq.boundary
      |-> ##[1:3] ackBusy) else $error("call did not start");
   call_length_a: assert property ($rose(ackBusy) |->
      ackBusy[*8] ##1 ackBusy[*5] ##1 !ackBusy) else $error("call length");
   push_order_a: assert property (pushPcHigh |->
      ##3 pushPcLow ##3 pushFlags) else $error("push order");
   flags_in_call_a: assert property (pushFlags |-> ackBusy)
      else $error("flags push outside call");
   no_request_busy_a: assert property (irqRequest |-> !ackBusy)
      else $error("request during call");
   vector_step_a: assert property ($changed(ackVector) |->
      ackVector[1:0] == 2'b00 && ackVector <= 8'h3c)
      else $error("bad vector");
   cover property ($rose(ackBusy));
   cover property (pslverr);
   cover property (pushFlags);
endmodule

bind prioritized_interrupt_controller irq_ctrl_checker chk (.clk(clk),
   .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .coreReq(coreReq), .irqRequest(irqRequest),
   .ackBusy(ackBusy), .ackVector(ackVector), .pushPcHigh(pushPcHigh),
   .pushPcLow(pushPcLow), .pushFlags(pushFlags));

// ---- testbench/cpu_core_model.sv ----
// Behavioural CPU core facing the controller
`timescale 1ns/1ps
module cpu_core_model
   import irq_ctrl_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ackBusy,
   input  wire logic retiReq,
   input  wire logic ieReq,
   output core_req_t coreReq
);
   logic phase_q;
   // Boundary every other cycle: a slow core, none after the first cycle of the call
   // boundaries, return, nesting
   always_ff @(posedge clk) begin
      if (!nrst) begin
         phase_q <= 1'b0;
         coreReq <= '0;
      end else begin
         phase_q          <= ~phase_q;
         coreReq.boundary <= phase_q & ~ackBusy;
         coreReq.return_from_interrupt     <= retiReq & ~ackBusy;
         coreReq.setIe    <= ieReq & ~ackBusy;
      end
   end
endmodule

// ---- testbench/tb_top.sv ----
// Register-level test of the interrupt controller with a core model
`timescale 1ns/1ps
module tb_top;
   import irq_ctrl_pkg::*;
   logic        clk;
   logic        nrst;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   irq_src_t    srcEvent;
   core_req_t   coreReq;
   logic        irqRequest;
   logic        ackBusy;
   logic [7:0]  ackVector;
   logic        retiReq;
   logic        ieReq;
   logic [31:0] rdData;
   logic        slvErr;
   int          failures;
   int          samples_checked;

   prioritized_interrupt_controller DUT (.clk(clk), .nrst(nrst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .srcEvent(srcEvent), .coreReq(coreReq), .irqRequest(irqRequest),
      .ackBusy(ackBusy), .ackVector(ackVector), .pushPcHigh(),
      .pushPcLow(), .pushFlags());
   cpu_core_model core (.clk(clk), .nrst(nrst), .ackBusy(ackBusy),
      .retiReq(retiReq), .ieReq(ieReq), .coreReq(coreReq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic final_report;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Hold the request until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // A missing answer counts as a mismatch
      if (pready !== 1'b1) begin
         failures++;
      end
      rdData = prdata;
      slvErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(rdData, exp);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task automatic ev(input logic [14:0] e);
      @(posedge clk);
      srcEvent <= irq_src_t'(e);
      @(posedge clk);
      srcEvent <= '0;
   endtask

   // Wait out one call and compare its vector; the return is left to the caller
   task automatic wait_ack(input logic [7:0] v);
      int n;
      n = 0;
      while (ackBusy !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      while (ackBusy === 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      // A call that never came or never ended is a mismatch
      if (n >= 60) begin
         failures++;
      end
      chk({24'h0, ackVector}, {24'h0, v});
   endtask

   task automatic do_return_from_interrupt;
      @(posedge clk);
      retiReq <= 1'b1;
      @(posedge clk);
      retiReq <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      final_report();
   end

   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, retiReq, ieReq} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      srcEvent = '0;
      failures = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd(12'h380, 32'h0);
      rd(12'h384, 32'h0);
      rd(12'h38c, 32'h0);
      rd(12'h3fc, 32'h0);
      chk({31'h0, slvErr}, 32'h1);
      wr(12'h380, 32'h7f);
      rd(12'h380, 32'h7f);
      wr(12'h380, 32'h00);
      ev(15'h000a);
      rd(12'h390, 32'h0);
      wr(12'h394, 32'hf3);
      ev(15'h410a);
      rd(12'h390, 32'h2409);
      rd(12'h388, 32'h04);
      rd(12'h390, 32'h2409);
      wr(12'h388, 32'h55);
      rd(12'h390, 32'h0);
      ev(15'h0001);
      rd(12'h388, 32'h3c);
      wr(12'h388, 32'h00);
      wr(12'h384, 32'h01);
      wr(12'h38c, 32'h01);
      ev(15'h0040);
      wait_ack(8'h08);
      rd(12'h38c, 32'h0);
      rd(12'h390, 32'h0);
      do_return_from_interrupt();
      rd(12'h38c, 32'h1);
      ev(15'h0080);
      chk({31'h0, irqRequest}, 32'h0);
      // Bracketed mask write keeps the zero vector away
      wr(12'h38c, 32'h00);
      wr(12'h384, 32'h03);
      chk({31'h0, irqRequest}, 32'h0);
      wr(12'h38c, 32'h01);
      wait_ack(8'h0c);
      do_return_from_interrupt();
      final_report();
   end
endmodule
